// ===== logic/gpe_pkg.sv
// constants, register map and encodings of the 8-pin port with external interrupts
// Behaviour
// - eight pins, bit X serves pin X
// - input mode reads sampled pin level
// - data writes in input mode only update latch
// - output mode drives latch, reads return latch
// - output option: 0 open-drain, 1 push-pull
// - push-pull drives both levels, open-drain releases high
// - input option: floating, or pull-up/interrupt variant
// - standard pins decode direction/option pair
// - interrupt input raises request on selected event
// - enabled interrupt pins combine by logical AND
// - pending latch hidden, cleared by vector fetch
// - changing sensitivity discards pending request
// - claimed alternate function overrides port programming
// - peripheral output forces output mode, its drive
// - peripheral input pins still readable in data
// - input plus alternate output reads alternate value
// - output plus alternate input feeds latch value
// - true open-drain pins: no option, no pull-up
// - low-power modes keep state, interrupts wake
// - falling, rising, both, fall+low, rise+high events
// - data, direction, option reset to zero
package gpe_pkg;

  // port and bus geometry
  localparam int PORT_W = 8;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;

  // register byte offsets
  localparam logic [AXI_AW-1:0] OFS_DATA  = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_DIR   = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_OPT   = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_SENS  = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_LEVEL = 8'h10;

  // field layout
  localparam int SENS_W   = 3;
  localparam int SENS_LSB = 0;
  localparam int PORT_LSB = 0;

  // reset values
  localparam logic [PORT_W-1:0] RST_DATA = 8'h00;
  localparam logic [PORT_W-1:0] RST_DIR  = 8'h00;
  localparam logic [PORT_W-1:0] RST_OPT  = 8'h00;
  localparam logic [SENS_W-1:0] RST_SENS = 3'h0;

  // sensitivity encodings
  localparam logic [SENS_W-1:0] SENS_FALL      = 3'h0;
  localparam logic [SENS_W-1:0] SENS_RISE      = 3'h1;
  localparam logic [SENS_W-1:0] SENS_BOTH      = 3'h2;
  localparam logic [SENS_W-1:0] SENS_FALL_LOW  = 3'h3;
  localparam logic [SENS_W-1:0] SENS_RISE_HIGH = 3'h4;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // default pin classes
  localparam logic [PORT_W-1:0] DEF_PU_MASK  = 8'hff;
  localparam logic [PORT_W-1:0] DEF_INT_MASK = 8'h0f;
  localparam logic [PORT_W-1:0] DEF_TOD_MASK = 8'h00;

endpackage

// ===== logic/gpe_sync.sv
// two-stage level synchroniser for a group of pin inputs
`timescale 1ns/10ps
module gpe_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         sys_rst_i,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } gpe_sync_t;

  gpe_sync_t st_r;
  gpe_sync_t st_nxt;

  // first stage feeds only the second stage
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.meta   = async_i;
    st_nxt.stable = st_r.meta;
  end

  // synchronous reset to a known low level
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign sync_o = st_r.stable;

endmodule

// ===== logic/gpe_port.sv
// 8-pin general purpose port with external interrupt and alternate functions
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module gpe_port #(
  parameter logic [gpe_pkg::PORT_W-1:0] PU_MASK  = gpe_pkg::DEF_PU_MASK,
  parameter logic [gpe_pkg::PORT_W-1:0] INT_MASK = gpe_pkg::DEF_INT_MASK,
  parameter logic [gpe_pkg::PORT_W-1:0] TOD_MASK = gpe_pkg::DEF_TOD_MASK,
  parameter bit                         HL_OK    = 1'b1
) (
  // clock and reset
  input  wire logic                         sys_clk_i,
  input  wire logic                         sys_rst_i,
  // axi4-lite write address
  input  wire logic                         s_axi_awvalid_i,
  output logic                              s_axi_awready_o,
  input  wire logic [gpe_pkg::AXI_AW-1:0]   s_axi_awaddr_i,
  input  wire logic [2:0]                   s_axi_awprot_i,
  // axi4-lite write data
  input  wire logic                         s_axi_wvalid_i,
  output logic                              s_axi_wready_o,
  input  wire logic [gpe_pkg::AXI_DW-1:0]   s_axi_wdata_i,
  input  wire logic [3:0]                   s_axi_wstrb_i,
  // axi4-lite write response
  output logic                              s_axi_bvalid_o,
  input  wire logic                         s_axi_bready_i,
  output logic      [1:0]                   s_axi_bresp_o,
  // axi4-lite read address
  input  wire logic                         s_axi_arvalid_i,
  output logic                              s_axi_arready_o,
  input  wire logic [gpe_pkg::AXI_AW-1:0]   s_axi_araddr_i,
  input  wire logic [2:0]                   s_axi_arprot_i,
  // axi4-lite read data
  output logic                              s_axi_rvalid_o,
  input  wire logic                         s_axi_rready_i,
  output logic      [gpe_pkg::AXI_DW-1:0]   s_axi_rdata_o,
  output logic      [1:0]                   s_axi_rresp_o,
  // package pins
  input  wire logic [gpe_pkg::PORT_W-1:0]   pin_i,
  output logic      [gpe_pkg::PORT_W-1:0]   pin_o,
  output logic      [gpe_pkg::PORT_W-1:0]   pin_oe_o,
  output logic      [gpe_pkg::PORT_W-1:0]   pin_pull_up_o,
  // on-chip peripheral alternate functions
  input  wire logic [gpe_pkg::PORT_W-1:0]   alt_en_i,
  input  wire logic [gpe_pkg::PORT_W-1:0]   alt_out_en_i,
  input  wire logic [gpe_pkg::PORT_W-1:0]   alt_out_i,
  input  wire logic [gpe_pkg::PORT_W-1:0]   alt_od_i,
  output logic      [gpe_pkg::PORT_W-1:0]   alt_in_o,
  // external interrupt request, also the wake-up request in wait and halt
  input  wire logic                         vector_fetch_i,
  output logic                              ext_irq_o
);

  localparam int W = gpe_pkg::PORT_W;

  typedef struct packed {
    logic [W-1:0]                 latch;
    logic [W-1:0]                 dir;
    logic [W-1:0]                 opt;
    logic [gpe_pkg::SENS_W-1:0]   sens;
    logic                         pend;
    logic                         lvl_q;
    logic [W-1:0]                 pin_o;
    logic [W-1:0]                 pin_oe;
    logic [W-1:0]                 pull;
    logic [W-1:0]                 alt_in;
    logic                         aw_hold;
    logic [gpe_pkg::AXI_AW-1:0]   aw_addr;
    logic                         w_hold;
    logic [gpe_pkg::AXI_DW-1:0]   w_data;
    logic [3:0]                   w_strb;
    logic                         awready;
    logic                         wready;
    logic                         bvalid;
    logic [1:0]                   bresp;
    logic                         arready;
    logic                         rvalid;
    logic [gpe_pkg::AXI_DW-1:0]   rdata;
    logic [1:0]                   rresp;
  } gpe_state_t;

  gpe_state_t st_r;
  gpe_state_t st_nxt;

  logic [W-1:0]                 pin_sync;
  logic [W-1:0]                 alt_drv;
  logic [W-1:0]                 eff_out;
  logic [W-1:0]                 drv_val;
  logic [W-1:0]                 drv_od;
  logic [W-1:0]                 od_rel;
  logic [W-1:0]                 rd_port;
  logic [W-1:0]                 int_en;
  logic                         grp_act;
  logic                         grp_lvl;
  logic                         fall_evt;
  logic                         rise_evt;
  logic                         evt;
  logic                         sens_chg;
  logic [gpe_pkg::AXI_AW-1:0]   rd_ofs;
  logic [gpe_pkg::AXI_AW-1:0]   wr_ofs;
  logic [gpe_pkg::AXI_DW-1:0]   rd_word;
  logic                         rd_hit;

  // pin levels are retimed before reads or event detection
  // the two-stage retiming costs two cycles of latency on every pin level
  gpe_sync #(
    .W         (W)
  ) u_pin_sync (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   (pin_i),
    .sync_o    (pin_sync)
  );

  // a peripheral that claims a pin and drives it wins over the port
  assign alt_drv = alt_en_i & alt_out_en_i;
  assign eff_out = st_r.dir | alt_drv;

  // driven value and driver type, peripheral first, then the latch
  assign drv_val = (alt_drv & alt_out_i) | (~alt_drv & st_r.latch);
  assign drv_od  = (alt_drv & alt_od_i)
                 | (~alt_drv & (~st_r.opt | TOD_MASK));

  // output pins in open-drain with a high level are released
  assign od_rel  = eff_out & drv_od & drv_val;

  // data reads: latch for outputs, alternate value or pin for inputs
  assign rd_port = (st_r.dir & st_r.latch)
                 | (~st_r.dir & alt_drv & alt_out_i)
                 | (~st_r.dir & ~alt_drv & pin_sync);

  // interrupt sources: capable pins in input mode with option set,
  // pins handed to a peripheral are left out so they cannot fire
  assign int_en  = INT_MASK & ~TOD_MASK & ~st_r.dir & st_r.opt & ~alt_en_i;
  assign grp_act = |int_en;
  // one low source holds the whole group low
  assign grp_lvl = &(pin_sync | ~int_en);

  // edges of the combined level; lvl_q idles high like the level with
  // no sources, so enabling a high source gives no false edge
  assign fall_evt = st_r.lvl_q & ~grp_lvl;
  assign rise_evt = ~st_r.lvl_q & grp_lvl;

  // event selection; level modes keep requesting while the level stays
  always_comb
  begin
    evt = 1'b0;
    unique case (st_r.sens)
      gpe_pkg::SENS_FALL:      evt = fall_evt;
      gpe_pkg::SENS_RISE:      evt = rise_evt;
      gpe_pkg::SENS_BOTH:      evt = fall_evt | rise_evt;
      gpe_pkg::SENS_FALL_LOW:  evt = fall_evt | ~grp_lvl;
      gpe_pkg::SENS_RISE_HIGH: evt = HL_OK ? (rise_evt | grp_lvl) : fall_evt;
      default:                 evt = fall_evt; // unused codes act as falling edge
    endcase
  end

  // aligned word offsets of the current requests; the two low address
  // bits and the protection attributes are ignored
  assign rd_ofs = {s_axi_araddr_i[gpe_pkg::AXI_AW-1:2], 2'h0};
  assign wr_ofs = {st_r.aw_addr[gpe_pkg::AXI_AW-1:2], 2'h0};

  // read decode; narrow registers sit in the low bits, the rest reads zero
  always_comb
  begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (rd_ofs)
      gpe_pkg::OFS_DATA:
      begin
        rd_word[gpe_pkg::PORT_LSB +: W] = rd_port;
      end
      gpe_pkg::OFS_DIR:
      begin
        rd_word[gpe_pkg::PORT_LSB +: W] = st_r.dir;
      end
      gpe_pkg::OFS_OPT:
      begin
        rd_word[gpe_pkg::PORT_LSB +: W] = st_r.opt & ~TOD_MASK;
      end
      gpe_pkg::OFS_SENS:
      begin
        rd_word[gpe_pkg::SENS_LSB +: gpe_pkg::SENS_W] = st_r.sens;
      end
      gpe_pkg::OFS_LEVEL:
      begin
        rd_word[gpe_pkg::PORT_LSB +: W] = pin_sync;
      end
      default:
      begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // next state: bus slave, register writes, interrupt latch, pin drivers
  always_comb
  begin
    st_nxt   = st_r;
    sens_chg = 1'b0;

    // one write at a time, so no id bookkeeping is needed
    // address and data are taken independently, in either order
    if (s_axi_awvalid_i && st_r.awready)
    begin
      st_nxt.aw_hold = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && st_r.wready)
    begin
      st_nxt.w_hold = 1'b1;
      st_nxt.w_data = s_axi_wdata_i;
      st_nxt.w_strb = s_axi_wstrb_i;
    end
    if (st_r.bvalid && s_axi_bready_i)
    begin
      st_nxt.bvalid = 1'b0;
    end

    // the write lands one cycle after both halves are held
    if (st_r.aw_hold && st_r.w_hold && !st_r.bvalid)
    begin
      st_nxt.aw_hold = 1'b0;
      st_nxt.w_hold  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = gpe_pkg::RESP_OKAY;
      unique case (wr_ofs)
        gpe_pkg::OFS_DATA:
        begin
          // stored in either direction when byte 0 is strobed, so the level is ready before output mode
          if (st_r.w_strb[0])
          begin
            st_nxt.latch = st_r.w_data[gpe_pkg::PORT_LSB +: W];
          end
        end
        gpe_pkg::OFS_DIR:
        begin
          if (st_r.w_strb[0])
          begin
            st_nxt.dir = st_r.w_data[gpe_pkg::PORT_LSB +: W];
          end
        end
        gpe_pkg::OFS_OPT:
        begin
          // true open-drain pins have no option bit to hold
          if (st_r.w_strb[0])
          begin
            st_nxt.opt = st_r.w_data[gpe_pkg::PORT_LSB +: W] & ~TOD_MASK;
          end
        end
        gpe_pkg::OFS_SENS:
        begin
          if (st_r.w_strb[0])
          begin
            st_nxt.sens = st_r.w_data[gpe_pkg::SENS_LSB +: gpe_pkg::SENS_W];
            sens_chg    = (st_nxt.sens != st_r.sens);
          end
        end
        gpe_pkg::OFS_LEVEL:
        begin
          st_nxt.bresp = gpe_pkg::RESP_OKAY; // read-only, write ignored
        end
        default:
        begin
          st_nxt.bresp = gpe_pkg::RESP_SLVERR;
        end
      endcase
    end

    // a held write blocks new ones until its response is taken
    st_nxt.awready = !st_nxt.aw_hold && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_hold && !st_nxt.bvalid;

    // read data is captured at the address handshake and then held
    // reads answer one cycle after the address is taken
    if (st_r.rvalid && s_axi_rready_i)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && st_r.arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_word;
      st_nxt.rresp  = rd_hit ? gpe_pkg::RESP_OKAY : gpe_pkg::RESP_SLVERR;
    end
    st_nxt.arready = !st_nxt.rvalid;

    // pending latch has no address; a new event beats either clear
    // the request then stays until the vector fetch or a sensitivity change
    st_nxt.lvl_q = grp_lvl;
    if (vector_fetch_i || sens_chg)
    begin
      st_nxt.pend = 1'b0;
    end
    if (grp_act && evt)
    begin
      st_nxt.pend = 1'b1;
    end

    // pin drivers, registered so the pads see clean levels;
    // open-drain only drives low, push-pull drives both levels
    st_nxt.pin_oe = eff_out & ~od_rel;
    // a released pin shows no value either, so nothing downstream
    // mistakes a stale level for a driven one
    st_nxt.pin_o  = drv_val & eff_out & ~od_rel;
    // pull-up only for inputs with option set, never on true open-drain
    st_nxt.pull   = ~eff_out & st_r.opt & PU_MASK & ~TOD_MASK;
    // peripheral input sees the latch when the pin is an output
    st_nxt.alt_in = (st_r.dir & st_r.latch) | (~st_r.dir & pin_sync);
  end

  // all port state except the pin synchroniser in one register; no power mode input touches it
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_r       <= '0;
      st_r.latch <= gpe_pkg::RST_DATA;
      st_r.dir   <= gpe_pkg::RST_DIR;
      st_r.opt   <= gpe_pkg::RST_OPT;
      st_r.sens  <= gpe_pkg::RST_SENS;
      st_r.lvl_q <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // bus outputs
  assign s_axi_awready_o = st_r.awready;
  assign s_axi_wready_o  = st_r.wready;
  assign s_axi_bvalid_o  = st_r.bvalid;
  assign s_axi_bresp_o   = st_r.bresp;
  assign s_axi_arready_o = st_r.arready;
  assign s_axi_rvalid_o  = st_r.rvalid;
  assign s_axi_rdata_o   = st_r.rdata;
  assign s_axi_rresp_o   = st_r.rresp;

  // pin and peripheral outputs
  assign pin_o         = st_r.pin_o;
  assign pin_oe_o      = st_r.pin_oe;
  assign pin_pull_up_o = st_r.pull;
  assign alt_in_o      = st_r.alt_in;

  // request doubles as wake-up from wait and halt
  assign ext_irq_o = st_r.pend;

endmodule

// ===== bench/gpe_pad_model.sv
// pad model: resolves each package pin from the port, an outside driver and the pull-up
`timescale 1ns/10ps
module gpe_pad_model (
  // clock
  input  wire logic       sys_clk_i,
  // port side
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] pin_oe_i,
  input  wire logic [7:0] pull_up_i,
  // outside driver
  input  wire logic [7:0] ext_val_i,
  input  wire logic [7:0] ext_en_i,
  // resolved level
  output logic      [7:0] pad_o
);
  // an undriven pad without pull wanders, so no check may lean on it
  logic [7:0] wander_r = 8'h55;

  always_ff @(posedge sys_clk_i)
    wander_r <= ~wander_r;

  // port driver wins, then the outside driver, then pull-up or wander
  always_comb
    pad_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_en_i & ext_val_i)
          | (~pin_oe_i & ~ext_en_i & (pull_up_i | wander_r));
endmodule

// ===== bench/gpe_port_checker.sv
// concurrent checks on the port's bus handshakes and pin outputs
`timescale 1ns/10ps
module gpe_port_checker (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  // bus handshakes
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic [31:0] s_axi_rdata_o,
  // pins and peripheral requests
  input wire logic [7:0]  pin_o,
  input wire logic [7:0]  pin_oe_o,
  input wire logic [7:0]  pin_pull_up_o,
  input wire logic [7:0]  alt_en_i,
  input wire logic [7:0]  alt_out_en_i,
  input wire logic [7:0]  alt_out_i,
  input wire logic [7:0]  alt_od_i
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // peripheral requests one edge ago, since the pin outputs are registered
  logic [7:0] pe_r;
  logic [7:0] po_r;
  logic [7:0] od_r;
  always_ff @(posedge sys_clk_i)
  begin
    pe_r <= sys_rst_i ? 8'h00 : (alt_en_i & alt_out_en_i);
    po_r <= alt_out_i;
    od_r <= alt_od_i;
  end

  AST_RST_IDLE: assert property ($fell(sys_rst_i) |-> pin_oe_o == 8'h00 && pin_pull_up_o == 8'h00)
    else $error("pins active after reset");
  AST_ALT_PP: assert property ((pin_oe_o & pe_r & ~od_r) == (pe_r & ~od_r)
    && (pin_o & pe_r & ~od_r) == (po_r & pe_r & ~od_r))
    else $error("peripheral push-pull output not driven");
  AST_ALT_OD: assert property ((pin_oe_o & pe_r & od_r) == (~po_r & pe_r & od_r))
    else $error("peripheral open-drain output wrong");
  AST_NO_DRIVE: assert property ((pin_o & ~pin_oe_o) == 8'h00)
    else $error("pin value without drive enable");
  AST_PU_OE: assert property ((pin_pull_up_o & pin_oe_o) == 8'h00)
    else $error("pull-up on an output pin");
  AST_RD_UPPER: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  AST_RD_LAT: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  AST_WR_RESP: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |=> ##1 s_axi_bvalid_o)
    else $error("write response late");
endmodule

bind gpe_port gpe_port_checker gpe_port_checker_inst (.*);

// ===== bench/gpe_port_tb.sv
// self-checking bench for the 8-pin port: bus, pin modes, alternate functions, interrupts
`timescale 1ns/10ps
module gpe_port_tb;
  // design ports, named as the port list so the instance connects by name
  logic        sys_clk_i, sys_rst_i, vector_fetch_i, ext_irq_o;
  logic        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, pin_i, pin_o, pin_oe_o, pin_pull_up_o, alt_in_o;
  logic [7:0]  alt_en_i, alt_out_en_i, alt_out_i, alt_od_i, ext_val, ext_en;
  logic [2:0]  s_axi_awprot_i, s_axi_arprot_i;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  int          failures = 0;
  int          n_checks = 0;
  int          cycles = 0;

  gpe_port gpe_port_inst (.*);
  gpe_pad_model gpe_pad_model_inst (.sys_clk_i(sys_clk_i), .pin_o_i(pin_o), .pin_oe_i(pin_oe_o),
    .pull_up_i(pin_pull_up_o), .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_o(pin_i));

  // clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    s_axi_awvalid_i <= 1'b1;
    s_axi_awaddr_i  <= a;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_wdata_i   <= d;
    while (!(ad && dd))
    begin
      @(posedge sys_clk_i);
      if (!ad && s_axi_awready_o === 1'b1)
      begin
        ad = 1'b1;
        s_axi_awvalid_i <= 1'b0;
      end
      if (!dd && s_axi_wready_o === 1'b1)
      begin
        dd = 1'b1;
        s_axi_wvalid_i <= 1'b0;
      end
    end
    do @(posedge sys_clk_i); while (s_axi_bvalid_o !== 1'b1);
    check("bresp", s_axi_bresp_o, er);
  endtask

  // read: compares the masked data and the response code together
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    s_axi_arvalid_i <= 1'b1;
    s_axi_araddr_i  <= a;
    do
    begin
      @(posedge sys_clk_i);
      if (s_axi_arready_o === 1'b1)
        s_axi_arvalid_i <= 1'b0;
    end
    while (s_axi_rvalid_o !== 1'b1);
    check("rdata", {s_axi_rresp_o, s_axi_rdata_o & m}, {er, e});
  endtask

  task automatic fetch();
    vector_fetch_i <= 1'b1;
    tick(1);
    vector_fetch_i <= 1'b0;
    tick(3);
  endtask

  // reset values, unmapped place, then all outputs driving the reset latch
  task automatic t_reset();
    rd(gpe_pkg::OFS_DIR, 32'hffffffff, 32'h0, gpe_pkg::RESP_OKAY);
    rd(gpe_pkg::OFS_OPT, 32'hffffffff, 32'h0, gpe_pkg::RESP_OKAY);
    rd(8'h14, 32'hffffffff, 32'h0, gpe_pkg::RESP_SLVERR);
    wr(8'h14, 32'hff, gpe_pkg::RESP_SLVERR);
    wr(gpe_pkg::OFS_DIR, 32'hff, gpe_pkg::RESP_OKAY);
    wr(gpe_pkg::OFS_OPT, 32'hff, gpe_pkg::RESP_OKAY);
    tick(2);
    check("oe", pin_oe_o, 8'hff);
    check("out", pin_o, 8'h00);
  endtask

  // mixed push-pull and open-drain, with the outside fighting released pins
  task automatic t_out();
    ext_val <= 8'ha5;
    wr(gpe_pkg::OFS_DATA, 32'h5a, gpe_pkg::RESP_OKAY);
    wr(gpe_pkg::OFS_OPT, 32'h0f, gpe_pkg::RESP_OKAY);
    tick(2);
    check("oe", pin_oe_o, 8'haf);
    check("out", pin_o, 8'h0a);
    rd(gpe_pkg::OFS_DATA, 32'hff, 32'h5a, gpe_pkg::RESP_OKAY);
  endtask

  // inputs read the pad, latch writes stay hidden until the pin turns output
  task automatic t_in();
    wr(gpe_pkg::OFS_DIR, 32'h00, gpe_pkg::RESP_OKAY);
    wr(gpe_pkg::OFS_OPT, 32'hf0, gpe_pkg::RESP_OKAY);
    wr(gpe_pkg::OFS_DATA, 32'h33, gpe_pkg::RESP_OKAY);
    tick(2);
    check("oe", pin_oe_o, 8'h00);
    check("pull", pin_pull_up_o, 8'hf0);
    rd(gpe_pkg::OFS_DATA, 32'hff, 32'ha5, gpe_pkg::RESP_OKAY);
    wr(gpe_pkg::OFS_DIR, 32'h0f, gpe_pkg::RESP_OKAY);
    tick(2);
    check("oe", pin_oe_o, 8'h0c);
  endtask

  // peripheral takes pins 2:0: drive, released open-drain, and an input
  task automatic t_alt();
    wr(gpe_pkg::OFS_DIR, 32'h00, gpe_pkg::RESP_OKAY);
    wr(gpe_pkg::OFS_OPT, 32'h00, gpe_pkg::RESP_OKAY);
    ext_val      <= 8'ha1;
    alt_en_i     <= 8'h07;
    alt_out_en_i <= 8'h05;
    alt_out_i    <= 8'h05;
    alt_od_i     <= 8'h04;
    tick(4);
    check("oe", pin_oe_o & 8'h07, 8'h01);
    check("out", pin_o & 8'h01, 8'h01);
    check("alt in", alt_in_o & 8'h02, 8'h00);
    rd(gpe_pkg::OFS_DATA, 32'h07, 32'h05, gpe_pkg::RESP_OKAY);
    wr(gpe_pkg::OFS_DATA, 32'h02, gpe_pkg::RESP_OKAY);
    wr(gpe_pkg::OFS_DIR, 32'h02, gpe_pkg::RESP_OKAY);
    tick(2);
    check("alt in", alt_in_o & 8'h02, 8'h02);
    {alt_en_i, alt_out_en_i, alt_out_i, alt_od_i} <= 32'h0;
    wr(gpe_pkg::OFS_DIR, 32'h00, gpe_pkg::RESP_OKAY);
  endtask

  // every sensitivity code, ordered so no level mode is live at a code change
  task automatic t_irq();
    logic [2:0] codes [5] = '{gpe_pkg::SENS_RISE, gpe_pkg::SENS_FALL_LOW, gpe_pkg::SENS_FALL,
                              gpe_pkg::SENS_RISE_HIGH, gpe_pkg::SENS_BOTH};
    logic       fromv [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    ext_val <= 8'h0e;
    wr(gpe_pkg::OFS_OPT, 32'h0f, gpe_pkg::RESP_OKAY);
    for (int i = 0; i < 5; i++)
    begin
      ext_val <= fromv[i] ? 8'h0f : 8'h0e;
      tick(4);
      wr(gpe_pkg::OFS_SENS, {29'h0, codes[i]}, gpe_pkg::RESP_OKAY);
      tick(4);
      check("irq idle", ext_irq_o, 1'b0);
      ext_val <= fromv[i] ? 8'h0e : 8'h0f;
      tick(6);
      check("irq event", ext_irq_o, 1'b1);
    end
    fetch();
    check("irq fetched", ext_irq_o, 1'b0);
    ext_val <= 8'h0d;
    tick(6);
    check("irq pin1", ext_irq_o, 1'b1);
    fetch();
    ext_val <= 8'h0c;
    tick(6);
    ext_val <= 8'h0d;
    tick(6);
    check("irq masked", ext_irq_o, 1'b0);
    wr(gpe_pkg::OFS_SENS, 32'h5, gpe_pkg::RESP_OKAY);
    ext_val <= 8'h0f;
    tick(6);
    check("irq spare rise", ext_irq_o, 1'b0);
    ext_val <= 8'h0e;
    tick(6);
    check("irq spare fall", ext_irq_o, 1'b1);
  endtask

  // main sequence: quiet inputs, 16-cycle reset, then the scenarios
  initial
  begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i, vector_fetch_i} = 4'h0;
    {s_axi_bready_i, s_axi_rready_i, sys_rst_i} = 3'h7;
    {s_axi_awaddr_i, s_axi_araddr_i, alt_en_i, alt_out_en_i} = 32'h0;
    {alt_out_i, alt_od_i, ext_val} = 24'h0;
    ext_en = 8'hff;
    s_axi_wdata_i = 32'h0;
    s_axi_wstrb_i = 4'hf;
    {s_axi_awprot_i, s_axi_arprot_i} = 6'h0;
    tick(16);
    sys_rst_i <= 1'b0;
    tick(1);
    t_reset();
    t_out();
    t_in();
    t_alt();
    t_irq();
    tally_and_finish();
  end
endmodule
